/* rtl/ultc_pkg.sv */
// Shared constants, register map and types of the serial transmit and receive core.
package ultc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_FMT = 6'h04;
  localparam logic [5:0] OFS_BAUD = 6'h08;
  localparam logic [5:0] OFS_TXBUF = 6'h0c;
  localparam logic [5:0] OFS_RXBUF = 6'h10;
  localparam logic [5:0] OFS_ACT = 6'h14;
  localparam logic [5:0] OFS_ERR = 6'h18;
  localparam logic [5:0] OFS_CLR = 6'h1c;
  localparam logic [5:0] OFS_TRIG = 6'h20;

  // ---------------------------------------------------------------------------
  // Bit positions in the clear and trigger registers
  // ---------------------------------------------------------------------------
  localparam int CLR_PE = 0;
  localparam int CLR_FE = 1;
  localparam int CLR_OVE = 2;
  localparam int CLR_DCE = 3;
  localparam int CLR_CONSIST = 7;
  localparam int TRIG_BREAK = 0;

  // ---------------------------------------------------------------------------
  // Reset values and fixed counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FMT_RST = 8'h01;
  localparam logic [15:0] BAUD_RST = 16'h0364;
  localparam logic [7:0] RXBUF_RST = 8'hff;
  localparam logic [4:0] BREAK_BITS = 5'h0d;
  localparam logic [4:0] LEN8_BITS = 5'h08;
  localparam logic [4:0] LEN7_BITS = 5'h07;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK} ultc_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ultc_rx_t;

  typedef struct packed {
    logic consistency_stop_mode;
    logic consistency_check_en;
    logic receive_enable_bit;
    logic transmit_enable_bit;
    logic power_bit;
  } ultc_ctrl_t;

  typedef struct packed {
    logic tx_irq_timing_sel;
    logic rx_inv;
    logic tx_inv;
    logic msb_first;
    logic stop2;
    logic [1:0] parity;
    logic len8;
  } ultc_fmt_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } ultc_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ultc_avs_rsp_t;

  typedef struct packed {
    ultc_ctrl_t ctrl;
    ultc_fmt_t fmt;
    logic [15:0] baud;
    logic [7:0] transmit_buffer;
    logic tx_pend;
    logic break_req;
    logic brk_active;
    logic dc_hold;
    ultc_tx_t tx_st;
    logic [7:0] transmit_shift_reg;
    logic [4:0] tx_cnt;
    logic tx_level;
    logic txd;
    logic cmp_pend;
    logic [7:0] cmp_data;
    ultc_rx_t rx_st;
    logic [7:0] receive_shift_reg;
    logic [4:0] rx_cnt;
    logic rx_par;
    logic rx_prev;
    logic [7:0] receive_buffer;
    logic rx_unread;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic consistency_error_flag;
    logic ack;
    logic waitreq;
    logic [31:0] readdata;
    logic tx_irq;
    logic rx_irq;
    logic st_irq;
  } ultc_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } ultc_sync_t;

endpackage

/* rtl/ultc_sync.sv */
// Three-stage input synchroniser with agreement filter for the receive pin.
`timescale 1ns/100ps
`default_nettype none
module ultc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  import ultc_pkg::*;

  ultc_sync_t r;
  ultc_sync_t n;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb begin
    n = r;
    n.s1 = din;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.level = r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign dout = r.level;
endmodule
`default_nettype wire

/* rtl/ultc_bit_timer.sv */
// Bit-period divider producing one-cycle enable pulses at the programmed baud rate.
`timescale 1ns/100ps
`default_nettype none
module ultc_bit_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic restart,
  input wire logic half,
  input wire logic [15:0] div,
  output logic tick
);
  import ultc_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  // A restart loads a full period, or half a period to land mid-bit.
  always_comb begin
    tick = 1'b0;
    cnt_next = cnt_reg;
    if (restart) begin
      cnt_next = half ? {1'b0, div[15:1]} : div;
    end else if (en) begin
      if (cnt_reg <= 16'h0001) begin
        tick = 1'b1;
        cnt_next = div;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* rtl/ultc_core.sv */
// Serial transmit and receive engine with consistency check and register slave.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ultc_core (
  input wire logic clk,
  input wire logic rst,
  input wire ultc_pkg::ultc_avs_req_t avs_req,
  output var ultc_pkg::ultc_avs_rsp_t avs_rsp,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic tx_irq,
  output logic rx_complete_irq,
  output logic status_irq
);
  import ultc_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] len_mask(input logic len8);
    return len8 ? 8'hff : 8'h7f;
  endfunction

  // Converts between the written value and the order bits travel in.
  function automatic logic [7:0] order_fix(input logic [7:0] d, input logic len8,
                                           input logic msb);
    logic [7:0] rev;
    rev = {<<{d}};
    if (!msb) begin
      return d & len_mask(len8);
    end
    return len8 ? rev : {1'b0, rev[7:1]};
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic len8, input logic [1:0] m);
    logic ones;
    ones = ^(d & len_mask(len8));
    case (m)
      PAR_EVEN: return ones;
      PAR_ODD: return ~ones;
      default: return 1'b0;
    endcase
  endfunction

  ultc_state_t r;
  ultc_state_t n;
  logic line;
  logic tx_tick;
  logic rx_tick;
  logic tx_restart;
  logic rx_restart;

  ultc_sync u_sync (
    .clk(clk),
    .rst(rst),
    .din(serial_in_pin),
    .dout(line)
  );

  ultc_bit_timer u_tx_tmr (
    .clk(clk),
    .rst(rst),
    .en(r.tx_st != TX_IDLE),
    .restart(tx_restart),
    .half(1'b0),
    .div(r.baud),
    .tick(tx_tick)
  );

  ultc_bit_timer u_rx_tmr (
    .clk(clk),
    .rst(rst),
    .en(r.rx_st != RX_IDLE),
    .restart(rx_restart),
    .half(1'b1),
    .div(r.baud),
    .tick(rx_tick)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic tx_ok;
    logic rx_ok;
    logic lvl;
    logic [7:0] rdat;
    logic pe;
    logic [4:0] dlen;
    logic txbuf_wr;
    tx_ok = r.ctrl.power_bit && r.ctrl.transmit_enable_bit;
    rx_ok = r.ctrl.power_bit &&
            (r.ctrl.receive_enable_bit || (r.ctrl.consistency_check_en && r.cmp_pend));
    lvl = line ^ r.fmt.rx_inv;
    dlen = r.fmt.len8 ? LEN8_BITS : LEN7_BITS;
    txbuf_wr = r.ack && avs_req.write && (avs_req.address == OFS_TXBUF);
    rdat = 8'h00;
    pe = 1'b0;
    n = r;
    n.tx_irq = 1'b0;
    n.rx_irq = 1'b0;
    n.st_irq = 1'b0;
    tx_restart = 1'b0;
    rx_restart = 1'b0;
    n.rx_prev = lvl;

    // -------------------------------------------------------------------------
    // Register bus: capture on request, act on the cycle waitrequest is low
    // -------------------------------------------------------------------------
    n.ack = (avs_req.read || avs_req.write) && !r.ack;
    n.waitreq = !n.ack;
    if (n.ack && avs_req.read) begin
      case (avs_req.address)
        OFS_CTRL: n.readdata = {27'h0, r.ctrl};
        OFS_FMT: n.readdata = {24'h0, r.fmt};
        OFS_BAUD: n.readdata = {16'h0, r.baud};
        OFS_TXBUF: n.readdata = {24'h0, r.transmit_buffer};
        OFS_RXBUF: n.readdata = {24'h0, r.receive_buffer};
        OFS_ACT: n.readdata = {27'h0, r.rx_unread, r.rx_st != RX_IDLE, r.tx_pend,
                               r.brk_active, r.tx_st != TX_IDLE && !r.brk_active};
        OFS_ERR: n.readdata = {27'h0, r.dc_hold, r.consistency_error_flag,
                               r.overrun_error_flag, r.framing_error_flag,
                               r.parity_error_flag};
        default: n.readdata = 32'h0;
      endcase
      // The read empties the buffer in the same cycle its value is captured, so a
      // frame finishing now is stored rather than reported as an overrun.
      if (avs_req.address == OFS_RXBUF) begin
        n.rx_unread = 1'b0;
      end
    end
    if (r.ack && avs_req.write) begin
      case (avs_req.address)
        OFS_CTRL: n.ctrl = avs_req.writedata[$bits(ultc_ctrl_t)-1:0];
        OFS_FMT: n.fmt = avs_req.writedata[$bits(ultc_fmt_t)-1:0];
        OFS_BAUD: n.baud = avs_req.writedata[15:0];
        OFS_TXBUF: begin
          n.transmit_buffer = avs_req.writedata[7:0];
          n.tx_pend = tx_ok;
        end
        OFS_CLR: begin
          if (avs_req.writedata[CLR_PE]) n.parity_error_flag = 1'b0;
          if (avs_req.writedata[CLR_FE]) n.framing_error_flag = 1'b0;
          if (avs_req.writedata[CLR_OVE]) n.overrun_error_flag = 1'b0;
          if (avs_req.writedata[CLR_DCE]) n.consistency_error_flag = 1'b0;
          if (avs_req.writedata[CLR_CONSIST]) n.dc_hold = 1'b0;
        end
        OFS_TRIG: begin
          if (avs_req.writedata[TRIG_BREAK] && tx_ok) n.break_req = 1'b1;
        end
        default: ;
      endcase
    end

    // -------------------------------------------------------------------------
    // Transmitter
    // -------------------------------------------------------------------------
    if (!tx_ok) begin
      n.tx_st = TX_IDLE;
      n.tx_pend = 1'b0;
      n.break_req = 1'b0;
      n.brk_active = 1'b0;
      n.dc_hold = 1'b0;
      n.cmp_pend = 1'b0;
      n.tx_level = 1'b1;
    end else begin
      case (r.tx_st)
        TX_IDLE: begin
          if (r.break_req) begin
            n.tx_st = TX_BREAK;
            n.break_req = 1'b0;
            n.brk_active = 1'b1;
            n.tx_cnt = BREAK_BITS;
            n.tx_level = 1'b0;
            n.tx_irq = !r.fmt.tx_irq_timing_sel;
            tx_restart = 1'b1;
          end else if (r.tx_pend && !r.dc_hold) begin
            n.tx_st = TX_START;
            // A buffer write landing in the load cycle stays pending for the next frame.
            n.tx_pend = txbuf_wr;
            n.transmit_shift_reg = order_fix(r.transmit_buffer, r.fmt.len8,
                                             r.fmt.msb_first);
            n.tx_cnt = dlen;
            n.tx_level = 1'b0;
            n.cmp_pend = r.ctrl.consistency_check_en;
            n.cmp_data = r.transmit_buffer;
            n.tx_irq = !r.fmt.tx_irq_timing_sel;
            tx_restart = 1'b1;
          end
        end
        TX_START, TX_DATA: begin
          if (tx_tick) begin
            if (r.tx_cnt != 5'h0) begin
              n.tx_st = TX_DATA;
              n.tx_level = r.transmit_shift_reg[0];
              n.transmit_shift_reg = {1'b0, r.transmit_shift_reg[7:1]};
              n.tx_cnt = r.tx_cnt - 5'h01;
            end else if (r.fmt.parity != PAR_NONE) begin
              n.tx_st = TX_PAR;
              n.tx_level = par_bit(r.cmp_data, r.fmt.len8, r.fmt.parity);
            end else begin
              n.tx_st = TX_STOP;
              n.tx_level = 1'b1;
              n.tx_cnt = {4'h0, r.fmt.stop2};
            end
          end
        end
        TX_PAR: begin
          if (tx_tick) begin
            n.tx_st = TX_STOP;
            n.tx_level = 1'b1;
            n.tx_cnt = {4'h0, r.fmt.stop2};
          end
        end
        TX_BREAK: begin
          if (tx_tick) begin
            n.tx_cnt = r.tx_cnt - 5'h01;
            if (r.tx_cnt == 5'h01) begin
              n.tx_st = TX_STOP;
              n.tx_level = 1'b1;
              n.tx_cnt = 5'h0;
            end
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            if (r.tx_cnt != 5'h0) begin
              n.tx_cnt = r.tx_cnt - 5'h01;
            end else begin
              n.tx_st = TX_IDLE;
              n.brk_active = 1'b0;
              n.tx_irq = r.fmt.tx_irq_timing_sel;
            end
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
    end
    n.txd = n.tx_level ^ n.fmt.tx_inv;

    // -------------------------------------------------------------------------
    // Receiver
    // -------------------------------------------------------------------------
    if (!rx_ok) begin
      n.rx_st = RX_IDLE;
    end else begin
      case (r.rx_st)
        RX_IDLE: begin
          if (r.rx_prev && !lvl) begin
            n.rx_st = RX_START;
            rx_restart = 1'b1;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            n.rx_st = lvl ? RX_IDLE : RX_DATA;
            n.rx_cnt = dlen;
            n.receive_shift_reg = 8'h00;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            n.receive_shift_reg = {lvl, r.receive_shift_reg[7:1]};
            n.rx_cnt = r.rx_cnt - 5'h01;
            if (r.rx_cnt == 5'h01) begin
              n.rx_st = (r.fmt.parity != PAR_NONE) ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_tick) begin
            n.rx_par = lvl;
            n.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            n.rx_st = RX_IDLE;
            rdat = order_fix(r.fmt.len8 ? r.receive_shift_reg
                                        : {1'b0, r.receive_shift_reg[7:1]},
                             r.fmt.len8, r.fmt.msb_first);
            pe = r.fmt.parity[1] && (par_bit(rdat, r.fmt.len8, r.fmt.parity) != r.rx_par);
            if (r.cmp_pend) begin
              n.cmp_pend = 1'b0;
              if (((rdat ^ r.cmp_data) & len_mask(r.fmt.len8)) != 8'h00) begin
                n.consistency_error_flag = 1'b1;
                n.st_irq = 1'b1;
                n.dc_hold = !r.ctrl.consistency_stop_mode;
              end
            end
            if (r.ctrl.receive_enable_bit) begin
              if (n.rx_unread) begin
                n.overrun_error_flag = 1'b1;
                n.st_irq = 1'b1;
              end else begin
                n.receive_buffer = rdat;
                n.rx_unread = 1'b1;
                if (pe) n.parity_error_flag = 1'b1;
                if (!lvl) n.framing_error_flag = 1'b1;
                if (pe || !lvl) begin
                  n.st_irq = 1'b1;
                end else begin
                  n.rx_irq = 1'b1;
                end
              end
            end
          end
        end
        default: n.rx_st = RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.fmt <= FMT_RST;
      r.baud <= BAUD_RST;
      r.receive_buffer <= RXBUF_RST;
      r.tx_level <= 1'b1;
      r.waitreq <= 1'b1;
      r.txd <= 1'b1;
      r.rx_prev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign avs_rsp.readdata = r.readdata;
  assign avs_rsp.waitrequest = r.waitreq;
  assign serial_out_pin = r.txd;
  assign tx_irq = r.tx_irq;
  assign rx_complete_irq = r.rx_irq;
  assign status_irq = r.st_irq;
endmodule
`default_nettype wire

/* tb/ultc_core_asserts.sv */
// Concurrent checks on the serial core ports.
`timescale 1ns/100ps
`default_nettype none
module ultc_core_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire ultc_pkg::ultc_avs_req_t avs_req,
  input wire ultc_pkg::ultc_avs_rsp_t avs_rsp,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic tx_irq,
  input wire logic rx_complete_irq,
  input wire logic status_irq
);
  import ultc_pkg::*;
  // ---------------------------------------------
  // Bus, line and interrupt checks
  // ---------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_IDLE: assert property ($fell(rst) |-> avs_rsp.waitrequest && serial_out_pin
    && !tx_irq && !status_irq) else $error("outputs busy after reset");
  AST_BUS_ANSWER: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("request not answered");
  AST_BUS_ONE: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("answer too long");
  AST_BUS_HOLE: assert property (avs_req.read && avs_rsp.waitrequest
    && avs_req.address > OFS_TRIG |=> avs_rsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  // The line may lag the write by one cycle, so the check starts one later.
  AST_ABORT_IDLE: assert property (
    avs_req.write && !avs_rsp.waitrequest && avs_req.address == OFS_CTRL
    && !avs_req.writedata[0] |=> ##1 (serial_out_pin && !tx_irq) [*6])
    else $error("line active after power down");
  AST_TX_PULSE: assert property (tx_irq |=> !tx_irq)
    else $error("transmit interrupt too long");
  AST_TX_AT_EDGE: assert property (tx_irq |-> $fell(serial_out_pin) || serial_out_pin)
    else $error("transmit interrupt mid frame");
  AST_RX_PULSE: assert property ($rose(rx_complete_irq) |=> $fell(rx_complete_irq))
    else $error("receive interrupt too long");
  AST_ST_GAP: assert property (status_irq |=> !status_irq [*4])
    else $error("status interrupt repeated");
endmodule
bind ultc_core ultc_core_asserts ultc_core_asserts_i (.clk(clk), .rst(rst),
  .avs_req(avs_req), .avs_rsp(avs_rsp), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_complete_irq(rx_complete_irq),
  .status_irq(status_irq));
`default_nettype wire

/* tb/ultc_node.sv */
// Remote serial node: drives the receive line and decodes the transmit line.
`timescale 1ns/100ps
`default_nettype none
module ultc_node #(
  parameter int BAUD = 16
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic [1:0] mode,
  output logic rxd,
  output logic [8:0] rx_byte,
  output logic rx_v
);
  logic drv = 1'b1;
  logic hold_lo = 1'b0;
  // Mode 1 echoes like a shared bus; mode 2 echoes the start edge, then the bus
  // is stuck dominant, so the receiver arms but sees corrupted data.
  always @(posedge clk) begin
    hold_lo <= (mode == 2'h2) && (hold_lo || !txd);
  end
  assign rxd = mode == 2'h1 ? txd : (mode == 2'h2 ? (txd && !hold_lo) : drv);
  task automatic level(input logic v, input int n);
    drv <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] v, input logic par, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, par, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      level(f[i], BAUD);
    end
  endtask
  // ---------------------------------------------
  // Decoder: mid-bit samples, a break reads as zero with a low stop bit.
  // ---------------------------------------------
  initial begin
    rx_v = 1'b0;
    rx_byte = 9'h0;
    forever begin
      @(negedge txd);
      repeat (BAUD / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BAUD) @(posedge clk);
        rx_byte[i] <= txd;
      end
      rx_v <= 1'b1;
      @(posedge clk);
      rx_v <= 1'b0;
      wait (txd === 1'b1);
    end
  end
endmodule
`default_nettype wire

/* tb/ultc_core_tb.sv */
// Self-checking bench: register bus, transmit and receive scenarios.
`timescale 1ns/100ps
`default_nettype none
module ultc_core_tb;
  import ultc_pkg::*;
  localparam int B = 16;
  logic clk, rst, sin, sout, tirq, rirq, sirq, nv;
  logic [1:0] mode;
  logic [8:0] nb;
  logic [7:0] d, d2;
  ultc_avs_req_t req;
  ultc_avs_rsp_t rsp;
  int miscompares, compares;
  int seed = 32'h3ebb;
  logic [31:0] rdq[$], iq[$], txq[$];
  ultc_core ultc_core_i (.clk(clk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
    .serial_in_pin(sin), .serial_out_pin(sout), .tx_irq(tirq),
    .rx_complete_irq(rirq), .status_irq(sirq));
  ultc_node #(.BAUD(B)) ultc_node_i (.clk(clk), .txd(sout), .mode(mode), .rxd(sin),
    .rx_byte(nb), .rx_v(nv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 32'hx;
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; one idle edge follows.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    req <= '{read: !w, write: w, address: a, writedata: v};
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic gap(input int n);
    repeat (n * B) @(posedge clk);
  endtask
  task automatic fin(input string n);
    cmp("pending notes", 32'h0, 32'(rdq.size() + iq.size() + txq.size()));
    $display("test %s done", n);
  endtask
  task automatic tx(input logic [7:0] v, input logic irq);
    if (irq) iq.push_back(32'h2);
    txq.push_back({23'h0, 1'b1, v});
    wr(OFS_TXBUF, {24'h0, v});
  endtask
  always @(posedge clk) begin
    if (req.read === 1'b1 && rsp.waitrequest === 1'b0) cmp("readdata", pop(rdq), rsp.readdata);
    if (tirq === 1'b1) cmp("tx irq", pop(iq), 32'h2);
    if (rirq === 1'b1) cmp("rx irq", pop(iq), 32'h3);
    if (sirq === 1'b1) cmp("status irq", pop(iq), 32'h4);
    if (nv === 1'b1) cmp("tx frame", pop(txq), {23'h0, nb});
  end
  initial begin
    #400000;
    miscompares++;
    results();
  end
  initial begin
    req = '0;
    rst = 1'b1;
    mode = 2'h1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_FMT, {24'h0, FMT_RST});
    rd(OFS_BAUD, {16'h0, BAUD_RST});
    rd(OFS_RXBUF, {24'h0, RXBUF_RST});
    wr(6'h24, 32'hff);
    rd(6'h24, 32'h0);
    fin("reset");
    wr(OFS_BAUD, B);
    wr(OFS_FMT, 32'h01);
    wr(OFS_CTRL, 32'h0b);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      tx(d, 1'b1);
      gap(11);
    end
    fin("transmit");
    mode <= 2'h2;
    tx(8'h5a, 1'b1);
    iq.push_back(32'h4);
    gap(11);
    mode <= 2'h1;
    rd(OFS_ERR, 32'h18);
    wr(OFS_TXBUF, 32'h33);
    gap(11);
    fin("mismatch hold");
    iq.push_back(32'h2);
    txq.push_back(32'h133);
    wr(OFS_CLR, 32'h88);
    gap(11);
    rd(OFS_ERR, 32'h0);
    fin("release");
    wr(OFS_CTRL, 32'h03);
    tx(8'ha1, 1'b1);
    wr(OFS_TXBUF, 32'hb2);
    tx(8'hc3, 1'b1);
    gap(23);
    fin("overwrite");
    tx(8'h11, 1'b1);
    iq.push_back(32'h2);
    txq.push_back(32'h0);
    tx(8'h22, 1'b1);
    wr(OFS_TRIG, 32'h1);
    gap(40);
    fin("break first");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FMT, 32'h81);
    wr(OFS_CTRL, 32'h03);
    tx(8'hff, 1'b0);
    gap(3);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_ACT, 32'h0);
    gap(11);
    fin("abort");
    wr(OFS_CTRL, 32'h03);
    tx(8'($random(seed)), 1'b1);
    gap(5);
    cmp("early irq", 32'h1, 32'(iq.size()));
    gap(7);
    fin("end irq");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FMT, 32'h07);
    wr(OFS_CTRL, 32'h05);
    mode <= 2'h0;
    d = 8'($random(seed));
    iq.push_back(32'h3);
    ultc_node_i.send(d, ^d, 1'b1);
    rd(OFS_RXBUF, {24'h0, d});
    d = 8'($random(seed));
    iq.push_back(32'h3);
    ultc_node_i.send(d, ^d, 1'b1);
    d2 = 8'($random(seed));
    iq.push_back(32'h4);
    ultc_node_i.send(d2, ^d2, 1'b1);
    rd(OFS_RXBUF, {24'h0, d});
    rd(OFS_ERR, 32'h04);
    d = 8'($random(seed));
    iq.push_back(32'h4);
    ultc_node_i.send(d, !(^d), 1'b1);
    rd(OFS_RXBUF, {24'h0, d});
    d = 8'($random(seed));
    iq.push_back(32'h4);
    ultc_node_i.send(d, ^d, 1'b0);
    rd(OFS_RXBUF, {24'h0, d});
    rd(OFS_ERR, 32'h07);
    wr(OFS_CLR, 32'h07);
    rd(OFS_ERR, 32'h0);
    ultc_node_i.level(1'b0, B / 4);
    ultc_node_i.level(1'b1, 2 * B);
    wr(OFS_CTRL, 32'h0);
    ultc_node_i.level(1'b0, 4);
    wr(OFS_CTRL, 32'h05);
    ultc_node_i.level(1'b0, 20 * B);
    ultc_node_i.level(1'b1, 2 * B);
    fin("receive");
    results();
  end
endmodule
`default_nettype wire
